//--- rtl/flash_status_params.svh
// Constants of the flash status controller: register map, field positions,
// flash status bit positions, command words and bus cycle timing.
// Assumes a 100 MHz system clock and an asynchronous parallel flash.
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define FS_CLK_NS 10
`define FS_T_RD_NS 70
`define FS_T_WP_NS 45
`define FS_RD_CYC ((`FS_T_RD_NS + `FS_CLK_NS - 1) / `FS_CLK_NS)
`define FS_WR_CYC ((`FS_T_WP_NS + `FS_CLK_NS - 1) / `FS_CLK_NS)

// ------------------------------------------------------------------
// Register map and fields
// ------------------------------------------------------------------
`define FS_REG_CTRL 8'h00
`define FS_REG_ADDR 8'h04
`define FS_REG_STATUS 8'h08
`define FS_REG_DATA 8'h0C
`define FS_CTRL_CHECK 0
`define FS_CTRL_ERASE 1
`define FS_CTRL_RESET 2
`define FS_CTRL_LEAVE 3
`define FS_CTRL_SKIP 4
`define FS_ST_BUSY 0
`define FS_ST_RES_LO 1
`define FS_ST_RES_HI 3
`define FS_ST_SECTOR 4
`define FS_ST_WINDOW 5
`define FS_ST_RYBY 6
`define FS_ST_TIMEOUT 7
`define FS_ST_SKIP 8
`define FS_ADDR_RESET 22'h000000

// ------------------------------------------------------------------
// Flash status bits and command words
// ------------------------------------------------------------------
`define FS_BIT_POLL 7
`define FS_BIT_BUSY_TOG 6
`define FS_BIT_TIMEOUT 5
`define FS_BIT_WINDOW 3
`define FS_BIT_SECTOR_TOG 2
`define FS_CMD_RESET 16'h00F0
`define FS_CMD_ERASE 16'h0030

`endif

//--- rtl/flash_status_pkg.sv
// Types shared by the flash status controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_status_pkg;

    // Pins driven toward the flash.
    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fpin_t;

    // Sequencer states.
    typedef enum logic [3:0] {
        S_IDLE, S_RD_A, S_RD_B, S_RD_C, S_RD_D, S_RD_DATA,
        S_WR_RST, S_PRE_CHK, S_WR_ERS, S_POST_A, S_POST_B
    } state_t;

    // Outcome of the last command.
    typedef enum logic [2:0] {
        RES_NONE, RES_OK, RES_FAIL, RES_LEFT, RES_CLOSED, RES_NACK, RES_RESET
    } result_t;

endpackage

//--- rtl/flash_bus_cycle.sv
// One asynchronous flash read or write cycle, strobed by chip select.
// Assumes data inputs are synchronous to the clock and start comes only
// while no cycle runs.
`timescale 1ns/1ps
`include "flash_status_params.svh"

module flash_bus_cycle (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic is_write,
    input wire logic [21:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] dq_in,
    output flash_status_pkg::fpin_t pins,
    output logic done,
    output logic [15:0] rdata
);
    import flash_status_pkg::*;

    logic active;
    logic gap;
    logic write_cyc;
    logic [3:0] cnt;
    wire [3:0] last_cnt = write_cyc ? 4'(`FS_WR_CYC - 1) : 4'(`FS_RD_CYC - 1);
    wire strobe_end = active && (cnt == last_cnt);

    // Strobes low for the access time, then a recovery cycle, then done.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
            gap <= 1'b0;
            write_cyc <= 1'b0;
            cnt <= 4'h0;
            done <= 1'b0;
            rdata <= 16'h0000;
            pins <= '{addr: 22'h000000, dq_out: 16'h0000, dq_oe: 1'b0,
                      ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        end else begin
            done <= 1'b0;
            if (start) begin
                active <= 1'b1;
                write_cyc <= is_write;
                cnt <= 4'h0;
                pins <= '{addr: addr, dq_out: wdata, dq_oe: is_write,
                          ce_n: 1'b0, oe_n: is_write, we_n: !is_write};
            end else if (strobe_end) begin
                active <= 1'b0;
                gap <= 1'b1;
                pins.ce_n <= 1'b1;
                pins.oe_n <= 1'b1;
                pins.we_n <= 1'b1;
                if (!write_cyc) begin
                    rdata <= dq_in;
                end
            end else if (active) begin
                cnt <= cnt + 4'h1;
            end else if (gap) begin
                gap <= 1'b0;
                done <= 1'b1;
                pins.dq_oe <= 1'b0; // Data held one cycle past the write strobe.
            end
        end
    end

endmodule

//--- rtl/flash_status_poll.sv
// Host side controller that checks program and erase status of a parallel
// flash through its data bus, issues the reset command and adds sectors.
// Assumes a software port with read data one cycle after the read strobe.
//
// What the document requires of the device and the host
// RQ1: Device toggles sector bit in erasing sectors.
// RQ2: Sector toggle valid after final write strobe.
// RQ3: Toggle advances on chip select framed reads.
// RQ4: Sector toggle same for erasing and suspended.
// RQ5: Begin every check with two consecutive reads.
// RQ6: Stopped toggle means done; next read data.
// RQ7: Toggling with timeout set: recheck, reset on failure.
// RQ8: Restart with double read after leaving.
// RQ9: Device sets timeout bit past pulse limit.
// RQ10: Programming zero to one fails with timeout.
// RQ11: Reset command after timeout returns read mode.
// RQ12: Erase window bit low, then high; restarts.
// RQ13: No erase window for whole chip erase.
// RQ14: Window check may be skipped if fast.
// RQ15: Window high: only erase suspend accepted.
// RQ16: Window low: further sector erases accepted.
// RQ17: Check window before and after each addition.
// RQ18: Window high after addition means pin busy.
// RQ19: Erasing sector status: sector bit toggles.
// RQ20: Other sectors: sector bit stays constant.
// RQ21: Status reads use a valid address.
// RQ22: Status reads address the busy bank.
// RQ23: Device outputs complement while programming.
// RQ24: Erase suspend: polling one, toggle stops.
// RQ25: Timeout bit set keeps ready busy low.
`timescale 1ns/1ps
`include "flash_status_params.svh"

module flash_status_poll (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output flash_status_pkg::fpin_t FLASH_PINS,
    input wire logic [15:0] FLASH_DQ_IN,
    input wire logic FLASH_READY_BUSY_N
);
    import flash_status_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // Release the asynchronous reset through two flip-flops.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    state_t state;
    state_t next_state;
    result_t result;
    result_t next_result;
    logic [21:0] addr_reg;
    logic skip_window;
    logic leave_req;
    logic [15:0] prev_rd;
    logic [15:0] data_reg;
    logic sector_seen;
    logic window_seen;
    logic timeout_seen;
    logic ryby_q;
    logic cyc_done;
    logic [15:0] cyc_rdata;

    // Register decode; check, erase and reset commands are taken only while idle, leave only while a command runs.
    wire wr_ctrl = REG_WR && (REG_ADDR == `FS_REG_CTRL);
    wire wr_addr = REG_WR && (REG_ADDR == `FS_REG_ADDR);
    wire idle = (state == S_IDLE);
    wire cmd_check = wr_ctrl && idle && REG_WDATA[`FS_CTRL_CHECK];
    wire cmd_erase = wr_ctrl && idle && REG_WDATA[`FS_CTRL_ERASE];
    wire cmd_reset = wr_ctrl && idle && REG_WDATA[`FS_CTRL_RESET];
    wire cmd_leave = wr_ctrl && REG_WDATA[`FS_CTRL_LEAVE];
    wire [31:0] status_word = {23'h000000, skip_window, timeout_seen, ryby_q,
                               window_seen, sector_seen, result, !idle};
    wire [31:0] rd_mux = (REG_ADDR == `FS_REG_CTRL) ? {27'h0000000, skip_window, 4'h0} :
                         (REG_ADDR == `FS_REG_ADDR) ? {10'h000, addr_reg} :
                         (REG_ADDR == `FS_REG_STATUS) ? status_word :
                         (REG_ADDR == `FS_REG_DATA) ? {16'h0000, data_reg} : 32'h00000000;

    // Configuration writes and read data one cycle after the strobe.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= `FS_ADDR_RESET;
            skip_window <= 1'b0;
            REG_RDATA <= 32'h00000000;
            ryby_q <= 1'b1;
        end else begin
            ryby_q <= FLASH_READY_BUSY_N;
            REG_RDATA <= REG_RD ? rd_mux : 32'h00000000;
            if (wr_addr && idle) begin
                addr_reg <= REG_WDATA[21:0];
            end
            if (wr_ctrl) begin
                skip_window <= REG_WDATA[`FS_CTRL_SKIP];
            end
        end
    end

    // ------------------------------------------------------------------
    // Status sequencer
    // ------------------------------------------------------------------
    // Toggle detection compares the busy toggle bit of two successive reads.
    wire toggle = prev_rd[`FS_BIT_BUSY_TOG] ^ cyc_rdata[`FS_BIT_BUSY_TOG];
    wire sector_tog = prev_rd[`FS_BIT_SECTOR_TOG] ^ cyc_rdata[`FS_BIT_SECTOR_TOG];
    wire go = (idle && (cmd_check || cmd_erase || cmd_reset)) || cyc_done;
    wire cyc_start = go && (next_state != S_IDLE);
    wire cyc_write = (next_state == S_WR_RST) || (next_state == S_WR_ERS);
    wire done_write = (state == S_WR_RST) || (state == S_WR_ERS);
    wire [15:0] cyc_wdata = (next_state == S_WR_RST) ? `FS_CMD_RESET : `FS_CMD_ERASE;

    // Next state and outcome, moved on a command in S_IDLE and on each finished bus cycle.
    always_comb begin
        next_state = state;
        next_result = result;
        case (state)
            S_IDLE: begin
                if (cmd_check) begin
                    next_state = S_RD_A; // RQ5 RQ8
                end else if (cmd_erase) begin
                    next_state = skip_window ? S_WR_ERS : S_PRE_CHK; // RQ14 RQ17
                end else if (cmd_reset) begin
                    next_state = S_WR_RST;
                end
            end
            S_RD_A: begin
                if (cyc_done) begin
                    next_state = S_RD_B; // RQ5
                end
            end
            S_RD_B: begin
                if (cyc_done) begin
                    if (!toggle) begin
                        next_state = S_RD_DATA; // RQ6
                    end else if (cyc_rdata[`FS_BIT_TIMEOUT]) begin
                        next_state = S_RD_C; // RQ7
                    end else if (leave_req) begin
                        next_state = S_IDLE;
                        next_result = RES_LEFT;
                    end else begin
                        next_state = S_RD_A; // RQ8
                    end
                end
            end
            S_RD_C: begin
                if (cyc_done) begin
                    next_state = S_RD_D;
                end
            end
            S_RD_D: begin
                if (cyc_done) begin
                    next_state = toggle ? S_WR_RST : S_RD_DATA; // RQ7 RQ11
                    next_result = toggle ? RES_FAIL : result;
                end
            end
            S_RD_DATA: begin
                if (cyc_done) begin
                    next_state = S_IDLE;
                    next_result = RES_OK; // RQ6
                end
            end
            S_WR_RST: begin
                if (cyc_done) begin
                    next_state = S_IDLE;
                    next_result = (result == RES_FAIL) ? RES_FAIL : RES_RESET; // RQ11
                end
            end
            S_PRE_CHK: begin
                if (cyc_done) begin
                    next_state = cyc_rdata[`FS_BIT_WINDOW] ? S_IDLE : S_WR_ERS; // RQ17
                    next_result = cyc_rdata[`FS_BIT_WINDOW] ? RES_CLOSED : result;
                end
            end
            S_WR_ERS: begin
                if (cyc_done) begin
                    next_state = S_POST_A; // RQ17
                end
            end
            S_POST_A: begin
                if (cyc_done) begin
                    next_state = S_POST_B;
                end
            end
            S_POST_B: begin
                if (cyc_done) begin
                    next_state = S_IDLE;
                    next_result = cyc_rdata[`FS_BIT_WINDOW] ? RES_NACK : RES_OK; // RQ17
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // State, outcome and captured status; a new command clears the timeout flag.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            result <= RES_NONE;
            leave_req <= 1'b0;
            prev_rd <= 16'h0000;
            data_reg <= 16'h0000;
            sector_seen <= 1'b0;
            window_seen <= 1'b0;
            timeout_seen <= 1'b0;
        end else begin
            state <= next_state;
            result <= (idle && go) ? RES_NONE : next_result;
            leave_req <= idle ? 1'b0 : (leave_req || cmd_leave);
            if (cyc_done && !done_write) begin
                prev_rd <= cyc_rdata;
                data_reg <= cyc_rdata;
                window_seen <= cyc_rdata[`FS_BIT_WINDOW];
                sector_seen <= sector_tog;
                timeout_seen <= timeout_seen || cyc_rdata[`FS_BIT_TIMEOUT];
            end else if (idle && go) begin
                timeout_seen <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Flash bus cycles
    // ------------------------------------------------------------------
    // Every status read and command write goes to the chosen address.
    flash_bus_cycle u_cycle (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(addr_reg), // RQ21 RQ22
        .wdata(cyc_wdata),
        .dq_in(FLASH_DQ_IN),
        .pins(FLASH_PINS),
        .done(cyc_done),
        .rdata(cyc_rdata)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [3:0] reads_since_go;
    // Counts finished reads since the last accepted command.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            reads_since_go <= 4'h0;
        end else if (idle && go) begin
            reads_since_go <= 4'h0;
        end else if (cyc_done && !done_write && reads_since_go != 4'hF) begin
            reads_since_go <= reads_since_go + 4'h1;
        end
    end

    double_read_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RQ5
        (cyc_done && state == S_RD_B) |-> reads_since_go >= 4'h1)
        else $error("Toggle decision made without two reads.");
    stopped_data_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RQ6
        (cyc_done && state == S_RD_B && !toggle) |=> state == S_RD_DATA ##0
        (state == S_RD_DATA) [*2])
        else $error("Stopped toggle not followed by a data read.");
    recheck_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RQ7
        (cyc_done && state == S_RD_B && toggle && cyc_rdata[`FS_BIT_TIMEOUT])
        |=> state == S_RD_C)
        else $error("Timeout seen without toggle recheck.");
    fail_reset_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RQ11
        (cyc_done && state == S_RD_D && toggle) |=> ##[1:3] (!FLASH_PINS.we_n &&
        FLASH_PINS.dq_out == `FS_CMD_RESET))
        else $error("Failed operation not followed by reset command.");
    restart_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RQ8
        cmd_check |=> (state == S_RD_A && reads_since_go == 4'h0))
        else $error("Status check did not restart at the double read.");
    status_addr_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RQ21
        (!FLASH_PINS.ce_n && !FLASH_PINS.oe_n) |-> FLASH_PINS.addr == addr_reg)
        else $error("Status read at an address other than the chosen one.");
    window_skip_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RQ14
        (cmd_erase && skip_window) |=> state == S_WR_ERS)
        else $error("Window check not skipped when asked.");
    window_after_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RQ17
        (cyc_done && state == S_WR_ERS) |=> state == S_POST_A ##1 !FLASH_PINS.ce_n)
        else $error("Sector addition not followed by a window check.");
endmodule

//--- testbench/flash_dev_model.sv
// Behavioural parallel flash that answers status reads and takes commands.
// Assumes controller strobes are registered on the same clock as this model.
`timescale 1ns/1ps
`include "flash_status_params.svh"

module flash_dev_model (
    input wire logic clk,
    input flash_status_pkg::fpin_t pins,
    output logic [15:0] dq,
    output logic ready_busy_n
);
    import flash_status_pkg::*;
    localparam logic [15:0] ARRAY_WORD = 16'h3C3C;
    int left;
    int win_cnt;
    int win_len;
    bit tmo;
    bit hang;
    bit sus;
    bit bt;
    bit st;
    bit rd_q = 1'b0;
    bit we_q = 1'b1;
    logic [15:0] word = 16'h0000;
    wire rd = !pins.ce_n && !pins.oe_n;
    wire in_sect = pins.addr[21:16] == 6'h01;

    // Starts an operation: reads left, timeout, stuck, window length, suspended.
    task automatic start_op(input int n, input bit t, input bit h, input int w, input bit s);
        left = n;
        tmo = t;
        hang = h;
        win_len = w;
        win_cnt = 0;
        sus = s;
    endtask

    // Builds one word per read cycle and advances the toggles; takes commands.
    always @(posedge clk) begin
        rd_q <= rd;
        we_q <= pins.we_n;
        if (rd && !rd_q) begin
            if (left > 0) begin
                word <= {8'h00, sus, bt, tmo, 1'b0, win_cnt >= win_len,
                         in_sect & st, 2'b00};
                bt = sus ? bt : ~bt;
                st = ~st;
                win_cnt = win_cnt + 1;
                left = (hang || sus) ? left : left - 1;
            end else begin
                word <= ARRAY_WORD;
            end
        end
        if (pins.we_n && !we_q) begin
            if (pins.dq_out == `FS_CMD_RESET) begin
                left = 0;
                tmo = 1'b0;
            end else if (pins.dq_out == `FS_CMD_ERASE && win_cnt < win_len) begin
                win_cnt = 0;
            end
        end
    end

    // A released bus shows the inverse of the last word.
    assign dq = rd_q ? word : ~word;
    assign ready_busy_n = !(left > 0 && !sus);
endmodule

//--- testbench/flash_status_poll_bench.sv
// Self-checking bench for the flash status controller.
// Assumes the design files and the flash model are compiled before it.
`timescale 1ns/1ps

module flash_status_poll_bench;
    import flash_status_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    fpin_t pins;
    logic [15:0] dq;
    logic rybn;
    logic [31:0] s;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;

    flash_status_poll dut (.CLK_SYS(clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .FLASH_PINS(pins), .FLASH_DQ_IN(dq), .FLASH_READY_BUSY_N(rybn));
    flash_dev_model model (.clk(clk), .pins(pins), .dq(dq), .ready_busy_n(rybn));

    // Makes the 100 MHz clock.
    initial begin
        forever #5 clk = ~clk;
    end

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Register access and checking
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data are taken at the edge that closes their one valid cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Issues a command, optionally asks to leave, then polls until idle.
    task automatic run(input logic [31:0] c, input bit lv);
        int n;
        wr(8'h00, c);
        if (lv) wr(8'h00, 32'h8);
        s = 32'h1;
        for (n = 0; n < 400 && s[0] !== 1'b0; n++) rd(8'h08, s);
        chk("idle", s & 32'h1, 32'h0);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h08, s);
        chk("status", s, 32'h40);
        rd(8'h04, s);
        chk("addr", s, 32'h0);
        rd(8'h10, s);
        chk("unmapped", s, 32'h0);
        $display("test reset done");
        wr(8'h04, 32'h0001_0020);
        run(32'h1, 1'b0);
        chk("result", s & 32'hE, 32'h2);
        model.start_op(5, 1'b0, 1'b0, 99, 1'b0);
        run(32'h1, 1'b0);
        chk("result", s & 32'hE, 32'h2);
        rd(8'h0C, s);
        chk("data", s, 32'h3C3C);
        $display("test check done");
        model.start_op(9, 1'b1, 1'b1, 99, 1'b0);
        rd(8'h08, s);
        chk("pin", s & 32'h40, 32'h0);
        run(32'h1, 1'b0);
        chk("fail", s & 32'hCE, 32'hC4);
        run(32'h1, 1'b0);
        chk("result", s & 32'hE, 32'h2);
        model.start_op(2, 1'b1, 1'b0, 99, 1'b0);
        run(32'h1, 1'b0);
        chk("result", s & 32'hE, 32'h2);
        $display("test timeout done");
        model.start_op(999, 1'b0, 1'b0, 0, 1'b0);
        run(32'h1, 1'b1);
        chk("left", s & 32'h3E, 32'h36);
        wr(8'h04, 32'h0002_0000);
        run(32'h1, 1'b1);
        chk("left", s & 32'h3E, 32'h26);
        run(32'h4, 1'b0);
        chk("result", s & 32'hE, 32'hC);
        $display("test leave done");
        wr(8'h04, 32'h0001_0000);
        model.start_op(999, 1'b0, 1'b0, 4, 1'b0);
        run(32'h2, 1'b0);
        chk("add", s & 32'h2E, 32'h2);
        run(32'h2, 1'b0);
        chk("add", s & 32'h2E, 32'h2);
        model.start_op(999, 1'b0, 1'b0, 1, 1'b0);
        run(32'h2, 1'b0);
        chk("nack", s & 32'h6E, 32'h2A);
        model.start_op(999, 1'b0, 1'b0, 0, 1'b0);
        run(32'h2, 1'b0);
        chk("closed", s & 32'hE, 32'h8);
        run(32'h4, 1'b0);
        $display("test erase add done");
        model.start_op(999, 1'b0, 1'b0, 0, 1'b1);
        run(32'h1, 1'b0);
        chk("suspend", s & 32'h5E, 32'h52);
        run(32'h4, 1'b0);
        $display("test suspend done");
        wr(8'h00, 32'h10);
        rd(8'h00, s);
        chk("ctrl", s, 32'h10);
        model.start_op(999, 1'b0, 1'b0, 0, 1'b0);
        run(32'h12, 1'b0);
        chk("skip", s & 32'h10E, 32'h10A);
        run(32'h4, 1'b0);
        $display("test skip done");
        test_done();
    end
endmodule
